// >>> hw/clock_dist_defs.svh
`ifndef CLOCK_DIST_DEFS_SVH
`define CLOCK_DIST_DEFS_SVH

// ------------------------------------------------------------
// Register offsets and reset values
// ------------------------------------------------------------
`define OFS_IFACE_CLK 7'h01
`define OFS_TX_PATH 7'h13
`define OFS_SYNTH 7'h15
`define OFS_AUX_SRC 7'h16
`define RST_IFACE_CLK 8'h00
`define RST_TX_PATH 8'h00
`define RST_SYNTH 8'h00
`define RST_AUX_SRC 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_AUX_EN 2
`define BIT_DCLK_INV 1
`define CLK_MODE_LSB 5
`define BIT_TX_FALL 5
`define UPS_LSB 0
`define BIT_BYPASS 7
`define BIT_ADC_HALF 5
`define BIT_RX_SRC 4
`define BIT_DIV5 3
`define MULT_LSB 0
`define BIT_AUX_SRC 5

// ------------------------------------------------------------
// Counts and limits
// ------------------------------------------------------------
`define MULT_MAX 3'h4
`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h08
`define TX_W 10
`define SYNC_W 19

`endif

// >>> hw/clock_dist_pkg.sv
package clock_dist_pkg;

  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_ADDR = 2'h1,
    SER_DATA = 2'h3
  } serial_state_e;

  typedef enum logic [3:0] {
    MODE_1 = 4'h1,
    MODE_2 = 4'h2,
    MODE_4 = 4'h4,
    MODE_5 = 4'h5,
    MODE_7 = 4'h7,
    MODE_8 = 4'h8,
    MODE_10 = 4'hA
  } clock_mode_e;

  typedef logic [7:0] reg_byte_t;

endpackage : clock_dist_pkg

// >>> hw/clock_divider.sv
`timescale 1ns/1ns
`default_nettype none

module clock_divider #(
  parameter int CW = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic [1:0] ratio_log2,
  output var logic clk_out
);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [CW-1:0] limit;
  logic clk_r;
  logic clk_nxt;

  // Half period is 2 to the ratio cycles, 4 for ratio 3; a new ratio is compared against the running count at once.
  always_comb begin
    case (ratio_log2)
      2'h0: limit = CW'(0);
      2'h1: limit = CW'(1);
      default: limit = CW'(3);
    endcase
    count_nxt = count_r + CW'(1);
    clk_nxt = clk_r;
    if (count_r >= limit) begin
      count_nxt = '0;
      clk_nxt = ~clk_r;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= '0;
      clk_r <= 1'b0;
    end else if (clock_enable) begin
      count_r <= count_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign clk_out = clk_r;

endmodule : clock_divider

`default_nettype wire

// >>> hw/transceiver_clock_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_dist_defs.svh"

module transceiver_clock_config
  import clock_dist_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic serial_select,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output var logic serial_data_out,
  output var logic serial_data_oe,
  input wire logic duplex_select_pin,
  input wire logic narrow_select,
  input wire logic [1:0] upsample_select_pins,
  input wire logic link_direction_pin,
  input wire logic aux_sync_clock_pin_in,
  output var logic aux_sync_clock_pin_out,
  output var logic aux_sync_clock_pin_oe,
  output var logic data_clock_pin,
  input wire logic [`TX_W-1:0] tx_data_pins,
  output var logic [`TX_W-1:0] tx_word,
  output var logic tx_word_valid,
  input wire logic [`TX_W-1:0] rx_word,
  output var logic [`TX_W-1:0] rx_data_pins,
  output var logic [2:0] synth_multiplier_code,
  output var logic synth_bypass,
  output var logic synth_fifth_divide,
  output var logic rx_from_synth,
  output var logic adc_clock_halved,
  output var logic [1:0] upsample_code,
  output var logic tx_latch_falling,
  output var clock_mode_e clock_mode,
  output var logic signed [3:0] tx_clock_shift,
  output var logic pin_mode,
  output var logic interleave_fault
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [`SYNC_W-1:0] meta_r;
  logic [`SYNC_W-1:0] sync_r;
  logic sclk_d_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
      sclk_d_r <= 1'b0;
    end else if (clock_enable) begin
      meta_r <= {serial_select, serial_clock, serial_data_in, duplex_select_pin, narrow_select,
                 upsample_select_pins, link_direction_pin, aux_sync_clock_pin_in, tx_data_pins};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[17];
    end
  end

  logic sel_s;
  logic sclk_s;
  logic sdi_s;
  logic fd_s;
  logic narrow_s;
  logic [1:0] ups_s;
  logic dir_tx_s;
  logic aux_in_s;
  logic [`TX_W-1:0] txd_s;
  logic sclk_rise;
  logic sclk_fall;

  assign {sel_s, sclk_s, sdi_s, fd_s, narrow_s, ups_s, dir_tx_s, aux_in_s, txd_s} = sync_r;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // ------------------------------------------------------------
  // Serial register port
  // ------------------------------------------------------------
  serial_state_e ser_state_r;
  serial_state_e ser_state_nxt;
  logic [4:0] bit_count_r;
  logic [4:0] bit_count_nxt;
  logic [15:0] shift_in_r;
  logic [15:0] shift_in_nxt;
  reg_byte_t shift_out_r;
  reg_byte_t shift_out_nxt;
  logic read_r;
  logic read_nxt;
  logic pin_mode_r;
  logic pin_mode_nxt;
  reg_byte_t iface_clk_r;
  reg_byte_t iface_clk_nxt;
  reg_byte_t tx_path_r;
  reg_byte_t tx_path_nxt;
  reg_byte_t synth_r;
  reg_byte_t synth_nxt;
  reg_byte_t aux_src_r;
  reg_byte_t aux_src_nxt;
  reg_byte_t read_data;
  logic [15:0] frame;

  always_comb begin
    ser_state_nxt = ser_state_r;
    bit_count_nxt = bit_count_r;
    shift_in_nxt = shift_in_r;
    shift_out_nxt = shift_out_r;
    read_nxt = read_r;
    iface_clk_nxt = iface_clk_r;
    tx_path_nxt = tx_path_r;
    synth_nxt = synth_r;
    aux_src_nxt = aux_src_r;
    frame = {shift_in_r[14:0], sdi_s};
    // Pin mode holds until the serial port is selected for the first time.
    pin_mode_nxt = pin_mode_r & ~sel_s;
    // The address sits in the low bits when the eighth bit arrives.
    case (frame[6:0])
      `OFS_IFACE_CLK: read_data = iface_clk_r;
      `OFS_TX_PATH: read_data = tx_path_r;
      `OFS_SYNTH: read_data = synth_r;
      `OFS_AUX_SRC: read_data = aux_src_r;
      default: read_data = 8'h00;
    endcase
    case (ser_state_r)
      SER_IDLE: begin
        bit_count_nxt = 5'h00;
        read_nxt = 1'b0;
        if (sel_s) begin
          ser_state_nxt = SER_ADDR;
        end
      end
      SER_ADDR: begin
        if (sclk_rise) begin
          shift_in_nxt = frame;
          bit_count_nxt = bit_count_r + 5'h01;
          if (bit_count_r + 5'h01 == `ADDR_BITS) begin
            read_nxt = frame[7];
            shift_out_nxt = read_data;
            ser_state_nxt = SER_DATA;
          end
        end
      end
      SER_DATA: begin
        if (sclk_fall && bit_count_r != `ADDR_BITS) begin
          shift_out_nxt = {shift_out_r[6:0], 1'b0};
        end
        if (sclk_rise && bit_count_r != `FRAME_BITS) begin
          shift_in_nxt = frame;
          bit_count_nxt = bit_count_r + 5'h01;
          if (bit_count_r + 5'h01 == `FRAME_BITS && !read_r) begin
            case (frame[14:8])
              `OFS_IFACE_CLK: iface_clk_nxt = frame[7:0];
              `OFS_TX_PATH: tx_path_nxt = frame[7:0];
              `OFS_SYNTH: synth_nxt = frame[7:0];
              `OFS_AUX_SRC: aux_src_nxt = frame[7:0];
              default: iface_clk_nxt = iface_clk_r;
            endcase
          end
        end
      end
      default: ser_state_nxt = SER_IDLE;
    endcase
    if (!sel_s) begin
      ser_state_nxt = SER_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ser_state_r <= SER_IDLE;
      bit_count_r <= 5'h00;
      shift_in_r <= 16'h0000;
      shift_out_r <= 8'h00;
      read_r <= 1'b0;
      pin_mode_r <= 1'b1;
      iface_clk_r <= `RST_IFACE_CLK;
      tx_path_r <= `RST_TX_PATH;
      synth_r <= `RST_SYNTH;
      aux_src_r <= `RST_AUX_SRC;
    end else if (clock_enable) begin
      ser_state_r <= ser_state_nxt;
      bit_count_r <= bit_count_nxt;
      shift_in_r <= shift_in_nxt;
      shift_out_r <= shift_out_nxt;
      read_r <= read_nxt;
      pin_mode_r <= pin_mode_nxt;
      iface_clk_r <= iface_clk_nxt;
      tx_path_r <= tx_path_nxt;
      synth_r <= synth_nxt;
      aux_src_r <= aux_src_nxt;
    end
  end

  // ------------------------------------------------------------
  // Effective clock configuration
  // ------------------------------------------------------------
  logic half_wide;
  logic interleaved;
  logic [2:0] mult_raw;
  logic [1:0] ups_raw;
  logic [1:0] ups_eff;
  logic [1:0] ups_log2;
  logic bypass_raw;
  logic [2:0] mode_field;
  logic [2:0] mult_r;
  logic [2:0] mult_nxt;
  logic [1:0] ups_r;
  logic bypass_r;
  logic div5_r;
  logic rx_src_r;
  logic adc_half_r;
  logic tx_fall_r;
  logic fault_r;
  clock_mode_e mode_r;
  clock_mode_e mode_nxt;
  logic signed [3:0] shift_r;
  logic signed [3:0] shift_nxt;
  logic [1:0] div_ratio;

  always_comb begin
    half_wide = ~fd_s & ~(pin_mode_r ? aux_in_s : narrow_s);
    mode_field = pin_mode_r ? 3'h0 : iface_clk_r[`CLK_MODE_LSB +: 3];
    if (fd_s) begin
      mode_nxt = (mode_field == 3'h0) ? MODE_1 : MODE_2;
    end else if (half_wide) begin
      mode_nxt = (mode_field == 3'h0) ? MODE_4 : MODE_5;
    end else begin
      case (mode_field)
        3'h0: mode_nxt = MODE_7;
        3'h1: mode_nxt = MODE_8;
        default: mode_nxt = MODE_10;
      endcase
    end
    if (pin_mode_r) begin
      case (ups_s)
        2'h0: begin
          ups_raw = half_wide ? 2'h0 : 2'h1;
          mult_raw = half_wide ? 3'h0 : 3'h1;
          bypass_raw = half_wide;
        end
        2'h1: begin
          ups_raw = 2'h1;
          mult_raw = 3'h1;
          bypass_raw = 1'b0;
        end
        default: begin
          ups_raw = 2'h2;
          mult_raw = 3'h2;
          bypass_raw = 1'b0;
        end
      endcase
    end else begin
      ups_raw = tx_path_r[`UPS_LSB +: 2];
      mult_raw = synth_r[`MULT_LSB +: 3];
      bypass_raw = synth_r[`BIT_BYPASS];
    end
    interleaved = ~half_wide;
    ups_eff = (interleaved && ups_raw == 2'h0) ? 2'h1 : ups_raw;
    ups_log2 = (ups_eff == 2'h3) ? 2'h2 : ups_eff;
    mult_nxt = (mult_raw <= `MULT_MAX) ? mult_raw : mult_r;
    shift_nxt = (bypass_raw ? 4'sh0 : signed'({1'b0, mult_nxt})) - signed'({2'b00, ups_log2})
              + signed'({3'b000, interleaved});
    div_ratio = ups_log2 - {1'b0, interleaved};
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mult_r <= 3'h0;
      ups_r <= 2'h0;
      bypass_r <= 1'b0;
      div5_r <= 1'b0;
      rx_src_r <= 1'b0;
      adc_half_r <= 1'b0;
      tx_fall_r <= 1'b0;
      fault_r <= 1'b0;
      mode_r <= MODE_1;
      shift_r <= 4'sh0;
    end else if (clock_enable) begin
      mult_r <= mult_nxt;
      ups_r <= ups_eff;
      bypass_r <= bypass_raw;
      div5_r <= ~pin_mode_r & synth_r[`BIT_DIV5];
      rx_src_r <= ~pin_mode_r & synth_r[`BIT_RX_SRC];
      adc_half_r <= ~pin_mode_r & synth_r[`BIT_ADC_HALF];
      tx_fall_r <= ~pin_mode_r & tx_path_r[`BIT_TX_FALL];
      fault_r <= interleaved && ups_raw == 2'h0;
      mode_r <= mode_nxt;
      shift_r <= shift_nxt;
    end
  end

  // ------------------------------------------------------------
  // Interface clock pins and data
  // ------------------------------------------------------------
  logic tx_clk_q;
  logic ref_img_q;
  logic tx_clk_d_r;
  logic dclk_r;
  logic dclk_nxt;
  logic aux_out_r;
  logic aux_out_nxt;
  logic aux_oe_r;
  logic aux_oe_nxt;
  logic aux_img;
  logic aux_en;
  logic tx_rise;
  logic tx_fallen;
  logic latch_edge;
  logic [`TX_W-1:0] tx_word_r;
  logic [`TX_W-1:0] tx_word_nxt;
  logic tx_valid_r;
  logic tx_valid_nxt;
  logic [`TX_W-1:0] rx_pins_r;
  logic [`TX_W-1:0] rx_pins_nxt;

  // Two dividers on one clock, reset and enable keep both images phase locked to the system clock.
  clock_divider #(.CW(2)) tx_clock_div (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .ratio_log2(div_ratio),
    .clk_out(tx_clk_q)
  );

  clock_divider #(.CW(2)) ref_image_div (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .ratio_log2(2'h0),
    .clk_out(ref_img_q)
  );

  always_comb begin
    aux_en = ~pin_mode_r & iface_clk_r[`BIT_AUX_EN];
    tx_rise = tx_clk_q & ~tx_clk_d_r;
    tx_fallen = ~tx_clk_q & tx_clk_d_r;
    aux_img = aux_src_r[`BIT_AUX_SRC] ? tx_clk_q : ref_img_q;
    aux_oe_nxt = fd_s | aux_en;
    if (fd_s) begin
      aux_out_nxt = aux_img ^ aux_en;
    end else begin
      aux_out_nxt = aux_en & aux_img;
    end
    dclk_nxt = tx_clk_q ^ (~pin_mode_r & iface_clk_r[`BIT_DCLK_INV]);
    latch_edge = tx_fall_r ? tx_fallen : tx_rise;
    tx_valid_nxt = latch_edge & (fd_s | dir_tx_s);
    tx_word_nxt = tx_valid_nxt ? txd_s : tx_word_r;
    rx_pins_nxt = (tx_rise && (fd_s || !dir_tx_s)) ? rx_word : rx_pins_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_clk_d_r <= 1'b0;
      dclk_r <= 1'b0;
      aux_out_r <= 1'b0;
      aux_oe_r <= 1'b0;
      tx_word_r <= '0;
      tx_valid_r <= 1'b0;
      rx_pins_r <= '0;
    end else if (clock_enable) begin
      tx_clk_d_r <= tx_clk_q;
      dclk_r <= dclk_nxt;
      aux_out_r <= aux_out_nxt;
      aux_oe_r <= aux_oe_nxt;
      tx_word_r <= tx_word_nxt;
      tx_valid_r <= tx_valid_nxt;
      rx_pins_r <= rx_pins_nxt;
    end
  end

  assign serial_data_out = shift_out_r[7];
  assign serial_data_oe = read_r;
  assign aux_sync_clock_pin_out = aux_out_r;
  assign aux_sync_clock_pin_oe = aux_oe_r;
  assign data_clock_pin = dclk_r;
  assign tx_word = tx_word_r;
  assign tx_word_valid = tx_valid_r;
  assign rx_data_pins = rx_pins_r;
  assign synth_multiplier_code = mult_r;
  assign synth_bypass = bypass_r;
  assign synth_fifth_divide = div5_r;
  assign rx_from_synth = rx_src_r;
  assign adc_clock_halved = adc_half_r;
  assign upsample_code = ups_r;
  assign tx_latch_falling = tx_fall_r;
  assign clock_mode = mode_r;
  assign tx_clock_shift = shift_r;
  assign pin_mode = pin_mode_r;
  assign interleave_fault = fault_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset || !clock_enable);

  sequence s_aux_disabled;
    !fd_s && !aux_en;
  endsequence

  sequence s_fd_inverting;
    fd_s && aux_en;
  endsequence

  sequence s_wide_bypass_pins;
    pin_mode_r && ups_s == 2'h0 && half_wide;
  endsequence

  AST_AUX_OFF: assert property (s_aux_disabled |=> !aux_sync_clock_pin_oe)
    else $error("aux pin driven while disabled");
  AST_AUX_FD_INV: assert property (s_fd_inverting |=> aux_sync_clock_pin_out == !$past(aux_img))
    else $error("aux output not inverted in full duplex");
  AST_DCLK_INV: assert property (
      !pin_mode_r && iface_clk_r[`BIT_DCLK_INV] |=> data_clock_pin == !$past(tx_clk_q))
    else $error("data clock not inverted");
  AST_TX_EDGE: assert property (tx_word_valid |-> $past(tx_fall_r) ? !tx_clk_d_r : tx_clk_d_r)
    else $error("transmit word latched on wrong edge");
  AST_MULT_HOLD: assert property (
      !pin_mode_r && synth_r[2:0] > `MULT_MAX |=> $stable(synth_multiplier_code))
    else $error("reserved multiplier code changed setting");
  AST_PIN_BYPASS: assert property (s_wide_bypass_pins |=> synth_bypass && upsample_code == 2'h0)
    else $error("pin bypass setting not applied");
  AST_FD_WIDTH_OUT: assert property (fd_s |=> aux_sync_clock_pin_oe)
    else $error("width pin not driven in full duplex");
  AST_RX_LAUNCH: assert property (tx_rise && (fd_s || !dir_tx_s) |=>
      rx_data_pins == $past(rx_word) && data_clock_pin != $past(iface_clk_r[`BIT_DCLK_INV]))
    else $error("receive word not launched at clock rise");
  AST_MODE_DEFAULT: assert property (pin_mode_r && fd_s |=> clock_mode == MODE_1)
    else $error("pin mode did not select mode one");
  AST_INTERLEAVE: assert property (!half_wide |=> upsample_code != 2'h0)
    else $error("interleaved mode without upsampling");

endmodule : transceiver_clock_config

`default_nettype wire

// >>> tb/host_data_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_dist_defs.svh"

module host_data_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic data_clock_pin,
  input wire logic [`TX_W-1:0] rx_data_pins,
  output var logic [`TX_W-1:0] tx_data_pins,
  output var logic [`TX_W-1:0] rx_seen
);
  logic dclk_r;

  // ------------------------------------------------------------
  // Host side of the data bus
  // ------------------------------------------------------------
  // A new word goes out just after the rise, so it sits still across the falling edge.
  always_ff @(posedge clock) begin
    dclk_r <= data_clock_pin;
    if (reset) begin
      tx_data_pins <= `TX_W'(0);
      rx_seen <= `TX_W'(0);
    end else if (data_clock_pin && !dclk_r) begin
      tx_data_pins <= tx_data_pins + `TX_W'(1);
      rx_seen <= rx_data_pins;
    end
  end
endmodule : host_data_model

`default_nettype wire

// >>> tb/transceiver_clock_distribution_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_dist_defs.svh"

module transceiver_clock_distribution_config_bench;
  import clock_dist_pkg::*;

  logic clock, reset, clock_enable, serial_select, serial_clock, serial_data_in;
  logic serial_data_out, serial_data_oe, duplex_select_pin, narrow_select, link_direction_pin;
  logic aux_in, aux_out, aux_oe, data_clock_pin, tx_word_valid, synth_bypass;
  logic synth_fifth_divide, rx_from_synth, adc_clock_halved, tx_latch_falling;
  logic pin_mode, interleave_fault, mon_on, rx_chg, exp_fall, exp_inv;
  logic [1:0] upsample_select_pins, upsample_code;
  logic [2:0] synth_multiplier_code;
  logic [`TX_W-1:0] tx_data_pins, rx_data_pins, rx_prev, tx_word;
  logic [`TX_W-1:0] rx_word = 10'h000;
  clock_mode_e clock_mode;
  logic signed [3:0] tx_clock_shift;
  int n_errors = 0;
  int checks_done = 0;
  int n_valid, n_rx;
  logic [11:0] pin_tbl [5] = '{12'h912, 12'hA14, 12'h041, 12'h142, 12'h674};
  logic [7:0] syn_tbl [5] = '{8'h80, 8'h21, 8'h12, 8'h0B, 8'h04};

  transceiver_clock_config transceiver_clock_config_inst (
    .clock(clock), .reset(reset), .clock_enable(clock_enable),
    .serial_select(serial_select), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .duplex_select_pin(duplex_select_pin),
    .narrow_select(narrow_select), .upsample_select_pins(upsample_select_pins),
    .link_direction_pin(link_direction_pin), .aux_sync_clock_pin_in(aux_in),
    .aux_sync_clock_pin_out(aux_out), .aux_sync_clock_pin_oe(aux_oe),
    .data_clock_pin(data_clock_pin), .tx_data_pins(tx_data_pins), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .rx_word(rx_word), .rx_data_pins(rx_data_pins),
    .synth_multiplier_code(synth_multiplier_code), .synth_bypass(synth_bypass),
    .synth_fifth_divide(synth_fifth_divide), .rx_from_synth(rx_from_synth),
    .adc_clock_halved(adc_clock_halved), .upsample_code(upsample_code),
    .tx_latch_falling(tx_latch_falling), .clock_mode(clock_mode),
    .tx_clock_shift(tx_clock_shift), .pin_mode(pin_mode),
    .interleave_fault(interleave_fault)
  );

  host_data_model host_data_model_inst (
    .clock(clock), .reset(reset), .data_clock_pin(data_clock_pin),
    .rx_data_pins(rx_data_pins), .tx_data_pins(tx_data_pins), .rx_seen()
  );

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The serial clock is kept slow so the sampled pin sees every phase.
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
                       output logic [7:0] rv);
    logic [15:0] f;
    f = {rd, addr, wd};
    rv = 8'h00;
    serial_select = 1'b1;
    step(4);
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = f[i];
      step(6);
      if (i < 8) rv[i] = serial_data_out;
      if (i == 0) check("read_oe", serial_data_oe, rd);
      serial_clock = 1'b1;
      step(6);
      serial_clock = 1'b0;
    end
    step(6);
    serial_select = 1'b0;
    step(6);
  endtask : frame

  task automatic wr(input logic [6:0] addr, input logic [7:0] wd);
    logic [7:0] dummy;
    frame(1'b0, addr, wd, dummy);
  endtask : wr

  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    frame(1'b1, addr, 8'h00, v);
    check("readback", v, exp);
  endtask : rd_chk

  // ------------------------------------------------------------
  // Data clock edge monitor
  // ------------------------------------------------------------
  always @(posedge clock) begin
    rx_word <= #1 rx_word + 10'h001;
    rx_prev <= rx_data_pins;
    rx_chg <= mon_on && (rx_data_pins !== rx_prev);
    if (mon_on && tx_word_valid === 1'b1) begin
      n_valid++;
      check("dclk_at_latch", data_clock_pin, {~exp_fall ^ exp_inv});
      // The latched word is the one on the pins now or the one just before it.
      check("tx_word", tx_data_pins - tx_word < 10'h002, 16'h0001);
    end
    if (rx_chg) begin
      n_rx++;
      check("dclk_after_rx", data_clock_pin, {~exp_inv});
    end
  end

  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic prev;
    int n_tog;
    clock_enable = 1'b1;
    reset = 1'b1;
    serial_select = 1'b0;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    duplex_select_pin = 1'b1;
    narrow_select = 1'b0;
    upsample_select_pins = 2'h1;
    link_direction_pin = 1'b1;
    aux_in = 1'b0;
    mon_on = 1'b0;
    exp_fall = 1'b0;
    exp_inv = 1'b0;
    step(8);
    reset = 1'b0;
    step(4);
    check("pin_mode", pin_mode, 16'h0001);
    check("clock_mode", clock_mode, MODE_1);
    foreach (pin_tbl[k]) begin
      {duplex_select_pin, aux_in, upsample_select_pins} = pin_tbl[k][11:8];
      step(8);
      check("clock_mode", clock_mode, pin_tbl[k][7:4]);
      check("upsample", upsample_code, pin_tbl[k][9:8]);
      check("mult", synth_multiplier_code, pin_tbl[k][3:1]);
      check("bypass", synth_bypass, pin_tbl[k][0]);
      check("aux_oe", aux_oe, pin_tbl[k][11]);
    end
    duplex_select_pin = 1'b1;
    rd_chk(`OFS_IFACE_CLK, 8'h00);
    rd_chk(`OFS_TX_PATH, 8'h00);
    rd_chk(`OFS_SYNTH, 8'h00);
    rd_chk(`OFS_AUX_SRC, 8'h00);
    check("pin_mode", pin_mode, 16'h0000);
    wr(7'h20, 8'hFF);
    rd_chk(7'h20, 8'h00);
    foreach (syn_tbl[k]) begin
      wr(`OFS_SYNTH, syn_tbl[k]);
      rd_chk(`OFS_SYNTH, syn_tbl[k]);
      check("bypass", synth_bypass, syn_tbl[k][7]);
      check("adc_half", adc_clock_halved, syn_tbl[k][5]);
      check("rx_src", rx_from_synth, syn_tbl[k][4]);
      check("div5", synth_fifth_divide, syn_tbl[k][3]);
      check("mult", synth_multiplier_code, syn_tbl[k][2:0]);
    end
    wr(`OFS_SYNTH, 8'h05);
    check("mult_reserved", synth_multiplier_code, 16'h0004);
    wr(`OFS_SYNTH, 8'h02);
    for (int u = 0; u < 3; u++) begin
      wr(`OFS_TX_PATH, 8'(u));
      check("upsample", upsample_code, (u == 0) ? 16'h0001 : 16'(u));
      check("fault", interleave_fault, u == 0);
      check("shift", tx_clock_shift, (u == 2) ? 16'h0001 : 16'h0002);
    end
    for (int m = 0; m < 4; m++) begin
      {exp_fall, exp_inv} = 2'(m);
      wr(`OFS_TX_PATH, {2'h0, exp_fall, 5'h02});
      wr(`OFS_IFACE_CLK, {6'h00, exp_inv, 1'b0});
      check("latch_edge", tx_latch_falling, exp_fall);
      n_valid = 0;
      n_rx = 0;
      mon_on = 1'b1;
      step(40);
      mon_on = 1'b0;
      step(2);
      check("saw_valid", n_valid > 0, 16'h0001);
      check("saw_rx", n_rx > 0, 16'h0001);
    end
    check("aux_oe_fd", aux_oe, 16'h0001);
    wr(`OFS_IFACE_CLK, 8'h04);
    check("aux_oe_fd_en", aux_oe, 16'h0001);
    duplex_select_pin = 1'b0;
    narrow_select = 1'b1;
    wr(`OFS_IFACE_CLK, 8'h04);
    check("clock_mode", clock_mode, MODE_7);
    check("aux_oe_on", aux_oe, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      prev = aux_out;
      step(1);
      check("aux_toggle", aux_out, {~prev});
    end
    wr(`OFS_AUX_SRC, 8'h20);
    n_tog = 0;
    for (int k = 0; k < 8; k++) begin
      prev = aux_out;
      step(1);
      n_tog += int'(aux_out != prev);
    end
    check("aux_synth_toggles", n_tog == 4, 16'h0001);
    exp_inv = 1'b0;
    link_direction_pin = 1'b0;
    step(4);
    n_valid = 0;
    n_rx = 0;
    mon_on = 1'b1;
    step(40);
    mon_on = 1'b0;
    step(2);
    check("hd_rx_valid", n_valid == 0, 16'h0001);
    check("hd_rx_launch", n_rx > 0, 16'h0001);
    wr(`OFS_IFACE_CLK, 8'h00);
    check("aux_oe_off", aux_oe, 16'h0000);
    report_and_stop();
  end
endmodule : transceiver_clock_distribution_config_bench

`default_nettype wire
